// ---- verilog/gcd_pkg.sv ----
package gcd_pkg;
  // Subcommand codes written to the control command pair
  localparam logic [15:0] SC_STATUS = 16'h0000;
  localparam logic [15:0] SC_DEV_TYPE = 16'h0001;
  localparam logic [15:0] SC_FW_REV = 16'h0002;
  localparam logic [15:0] SC_SI_REV = 16'h0003;
  localparam logic [15:0] SC_FLASH_SUM = 16'h0004;
  localparam logic [15:0] SC_RESET_CNT = 16'h0005;
  localparam logic [15:0] SC_LAST_SC = 16'h0007;
  localparam logic [15:0] SC_CHEMISTRY_IDENTIFIER_REPORT = 16'h0008;
  localparam logic [15:0] SC_BOARD_OFF = 16'h0009;
  localparam logic [15:0] SC_CC_OFF = 16'h000a;
  localparam logic [15:0] SC_STORE_CC = 16'h000b;
  localparam logic [15:0] SC_HIB_SET = 16'h0011;
  localparam logic [15:0] SC_HIB_CLR = 16'h0012;
  localparam logic [15:0] SC_LOCK = 16'h0020;
  localparam logic [15:0] SC_GAUGE_START = 16'h0021;

  // Status word bit positions (high byte bits 14..10, low byte 6..0)
  localparam int SB_FAS = 14;
  localparam int SB_LOCKED = 13;
  localparam int SB_CSV = 12;
  localparam int SB_CCA = 11;
  localparam int SB_BCA = 10;
  localparam int SB_HIB = 6;
  localparam int SB_SLEEP = 4;
  localparam int SB_CONSTANT_POWER_FLAG = 3;
  localparam int SB_RESISTANCE_UPDATE_DISABLE_FLAG = 2;
  localparam int SB_VOK = 1;
  localparam int SB_QEN = 0;

  // Reset values
  localparam logic [15:0] RESULT_RST = 16'h0000;
  localparam logic [7:0] UPD_STATUS_RST = 8'h00;
  localparam logic [7:0] UPD_STATUS_RUN = 8'h01;

  // Timing: each offset phase lasts 16 s, board offset uses two
  localparam longint unsigned CLK_HZ = 100_000_000;
  localparam longint unsigned PHASE_S = 16;
  localparam longint unsigned PHASE_CYC = PHASE_S * CLK_HZ;
  localparam int SUM_DEPTH = 256;

  typedef enum logic [1:0] {
    GCD_IDLE = 2'b00,
    GCD_SUM = 2'b01,
    GCD_SHORT = 2'b10,
    GCD_OPEN = 2'b11
  } gcd_fsm_t;

  typedef enum logic {
    GCD_WR_BOARD = 1'b0,
    GCD_WR_CC = 1'b1
  } gcd_wr_sel_t;

  // Live status levels from the rest of the gauge
  typedef struct packed {
    logic full_access_locked_flag;
    logic sleep;
    logic constant_power_flag;
    logic resistance_update_disable_flag;
  } gcd_live_t;

  // Flash write request toward the data flash
  typedef struct packed {
    logic en;
    gcd_wr_sel_t sel;
    logic [15:0] data;
  } gcd_fwr_t;
endpackage

// ---- verilog/gcd_phase_timer.sv ----
`timescale 1ns/1ps
module gcd_phase_timer #(
  parameter longint unsigned CYC = gcd_pkg::PHASE_CYC
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic start_in,
  output logic done_out
);
  typedef struct packed {
    logic run;
    logic done;
    logic [31:0] cnt;
  } gcd_tmr_st_t;

  localparam logic [31:0] LAST = 32'(CYC - 1);

  gcd_tmr_st_t s_q;
  gcd_tmr_st_t s_d;

  // Counter must fit 32 bits and be at least one cycle
  if (CYC < 1 || CYC > 64'h0000_0000_ffff_ffff) begin : g_chk
    $error("gcd_phase_timer: CYC out of range");
  end

  // Start is ignored while running
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    if (s_q.run) begin
      if (s_q.cnt == 32'h0) begin
        s_d.run = 1'b0;
        s_d.done = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt - 32'h1;
      end
    end else if (start_in) begin
      s_d.run = 1'b1;
      s_d.cnt = LAST;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign done_out = s_q.done;
endmodule

// ---- verilog/gcd_flash_sum.sv ----
`timescale 1ns/1ps
module gcd_flash_sum #(
  parameter int DEPTH = gcd_pkg::SUM_DEPTH,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic start_in,
  input wire logic [7:0] data_in,
  output logic rd_out,
  output logic [AW-1:0] addr_out,
  output logic done_out,
  output logic [15:0] sum_out
);
  typedef struct packed {
    logic run;
    logic pend;
    logic done;
    logic [AW-1:0] addr;
    logic [15:0] acc;
  } gcd_sum_st_t;

  gcd_sum_st_t s_q;
  gcd_sum_st_t s_d;

  // Address must reach DEPTH-1, or the sweep would stop early
  if (DEPTH < 2 || AW < $clog2(DEPTH)) begin : g_chk
    $error("gcd_flash_sum: DEPTH or AW out of range");
  end

  // One read per cycle; data returns one cycle after the read strobe
  always_comb begin
    s_d = s_q;
    s_d.done = s_q.pend && !s_q.run;
    s_d.pend = s_q.run;
    if (s_q.pend) begin
      s_d.acc = s_q.acc + {8'h00, data_in};
    end
    if (s_q.run) begin
      if (s_q.addr == AW'(DEPTH - 1)) begin
        s_d.run = 1'b0;
      end else begin
        s_d.addr = s_q.addr + AW'(1);
      end
    end else if (start_in && !s_q.pend) begin
      s_d.run = 1'b1;
      s_d.addr = '0;
      s_d.acc = 16'h0000;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rd_out = s_q.run;
  assign addr_out = s_q.addr;
  assign done_out = s_q.done;
  assign sum_out = s_q.acc;
endmodule

// ---- verilog/gcd_subcmd_decoder.sv ----
`timescale 1ns/1ps
// How it works
// [R1] Two-byte subcommand selects the control function
// [R2] Locked state accepts only the listed subcommands
// [R3] Code 0x0000 returns the status word
// [R4] Status high byte: access, checksum, calibration flags
// [R5] Status low byte: power, gauging mode flags
// [R6] Deep low power request resets to zero
// [R7] Codes 1..3 return type and revisions
// [R8] Open: checksum flash, store and return it
// [R9] Locked: checksum readable, never recomputed
// [R10] Reset counts: full low, partial high
// [R11] Code 0x0007 returns previous subcommand
// [R12] Code 0x0008 returns chemistry identifier
// [R13] Board offset: short, open, difference, store
// [R14] Host keeps sense current off while measuring
// [R15] Locked board offset returns stored value
// [R16] Open: internal offset measured with short
// [R17] Locked internal offset returns stored value
// [R18] Code 0x000b writes internal offset to flash
// [R19] Set deep low power request; auto clear
// [R20] Clear deep low power request
// [R21] Code 0x0020 moves open to locked
// [R22] Gauging start sets update status, flags
// [R23] Access state gates every subcommand
// [R24] Undefined codes leave everything unchanged
// [R25] Host writes code, then reads result
module gcd_subcmd_decoder #(
  parameter longint unsigned PHASE_CYC = gcd_pkg::PHASE_CYC,
  parameter int SUM_DEPTH = gcd_pkg::SUM_DEPTH,
  parameter int SUM_AW = $clog2(SUM_DEPTH),
  parameter logic [15:0] DEV_TYPE = 16'h1234, // Arbitrary value
  parameter logic [15:0] FW_REV = 16'h0101, // Arbitrary value
  parameter logic [15:0] SI_REV = 16'h0001, // Arbitrary value
  parameter logic [15:0] CHEMISTRY_IDENTIFIER_REPORT = 16'h0042 // Arbitrary value
) (
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  input wire logic cmd_wr_in,
  input wire logic [15:0] cmd_code_in,
  input wire gcd_pkg::gcd_live_t live_in,
  input wire logic volt_bad_in,
  input wire logic hib_exit_in,
  input wire logic [7:0] full_rst_cnt_in,
  input wire logic [7:0] part_rst_cnt_in,
  input wire logic [15:0] cc_sample_in,
  input wire logic [15:0] flash_board_off_in,
  input wire logic [15:0] flash_cc_off_in,
  input wire logic [7:0] flash_data_in,
  output logic [15:0] result_out,
  output logic locked_out,
  output logic hib_req_out,
  output logic short_en_out,
  output logic busy_out,
  output logic gauge_start_out,
  output logic [7:0] upd_status_out,
  output logic flash_rd_out,
  output logic [SUM_AW-1:0] flash_addr_out,
  output gcd_pkg::gcd_fwr_t flash_wr_out
);
  typedef struct packed {
    gcd_pkg::gcd_fsm_t fsm;
    logic busy;
    logic locked;
    logic hib;
    logic voltage_ok_flag;
    logic capacity_update_enable_flag;
    logic checksum_valid_flag;
    logic bca;
    logic cca;
    logic board;
    logic short_en;
    logic sum_go;
    logic tmr_go;
    logic gauge_start;
    logic [7:0] upd;
    logic [15:0] result;
    logic [15:0] last;
    logic [15:0] sum;
    logic [15:0] cc_off;
    logic [15:0] first;
    gcd_pkg::gcd_fwr_t fwr;
  } gcd_top_st_t;

  gcd_top_st_t s_q;
  gcd_top_st_t s_d;
  logic [1:0] rst_sync_q;
  logic rst_n;
  logic [15:0] stat_w;
  logic cmd_ok;
  logic take;
  logic tmr_done;
  logic sum_done;
  logic [15:0] sum_val;

  // Code has a defined function
  function automatic logic is_known(input logic [15:0] c);
    case (c)
      gcd_pkg::SC_STATUS, gcd_pkg::SC_DEV_TYPE, gcd_pkg::SC_FW_REV,
      gcd_pkg::SC_SI_REV, gcd_pkg::SC_FLASH_SUM, gcd_pkg::SC_RESET_CNT,
      gcd_pkg::SC_LAST_SC, gcd_pkg::SC_CHEMISTRY_IDENTIFIER_REPORT, gcd_pkg::SC_BOARD_OFF,
      gcd_pkg::SC_CC_OFF, gcd_pkg::SC_STORE_CC, gcd_pkg::SC_HIB_SET,
      gcd_pkg::SC_HIB_CLR, gcd_pkg::SC_LOCK,
      gcd_pkg::SC_GAUGE_START: is_known = 1'b1;
      default: is_known = 1'b0;
    endcase
  endfunction

  // Codes served while locked; the three measuring ones only read back
  function automatic logic locked_ok(input logic [15:0] c);
    case (c)
      gcd_pkg::SC_STATUS, gcd_pkg::SC_DEV_TYPE, gcd_pkg::SC_FW_REV,
      gcd_pkg::SC_SI_REV, gcd_pkg::SC_CHEMISTRY_IDENTIFIER_REPORT, gcd_pkg::SC_HIB_SET,
      gcd_pkg::SC_HIB_CLR, gcd_pkg::SC_FLASH_SUM, gcd_pkg::SC_BOARD_OFF,
      gcd_pkg::SC_CC_OFF: locked_ok = 1'b1;
      default: locked_ok = 1'b0;
    endcase
  endfunction

  // Reset release through two flops; assertion is immediate
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // Status word assembly
  always_comb begin
    stat_w = 16'h0000;
    stat_w[gcd_pkg::SB_FAS] = live_in.full_access_locked_flag; // [R4]
    stat_w[gcd_pkg::SB_LOCKED] = s_q.locked; // [R4]
    stat_w[gcd_pkg::SB_CSV] = s_q.checksum_valid_flag; // [R4]
    stat_w[gcd_pkg::SB_CCA] = s_q.cca; // [R4]
    stat_w[gcd_pkg::SB_BCA] = s_q.bca; // [R4]
    stat_w[gcd_pkg::SB_HIB] = s_q.hib; // [R5]
    stat_w[gcd_pkg::SB_SLEEP] = live_in.sleep; // [R5]
    stat_w[gcd_pkg::SB_CONSTANT_POWER_FLAG] = live_in.constant_power_flag; // [R5]
    stat_w[gcd_pkg::SB_RESISTANCE_UPDATE_DISABLE_FLAG] = live_in.resistance_update_disable_flag; // [R5]
    stat_w[gcd_pkg::SB_VOK] = s_q.voltage_ok_flag; // [R5]
    stat_w[gcd_pkg::SB_QEN] = s_q.capacity_update_enable_flag; // [R5]
  end

  // Access gate on every written code
  assign cmd_ok = is_known(cmd_code_in) && (!s_q.locked || locked_ok(cmd_code_in)); // [R2] [R23] [R24]
  assign take = cmd_wr_in && cmd_ok; // [R1]

  // Next state: sequencer first, then the written command
  always_comb begin
    s_d = s_q;
    s_d.fwr.en = 1'b0;
    s_d.gauge_start = 1'b0;
    s_d.sum_go = 1'b0;
    s_d.tmr_go = 1'b0;
    if (hib_exit_in) begin
      s_d.hib = 1'b0; // [R19]
    end
    if (volt_bad_in) begin
      s_d.voltage_ok_flag = 1'b0; // [R22]
    end
    unique case (s_q.fsm)
      gcd_pkg::GCD_IDLE: begin
      end
      gcd_pkg::GCD_SUM: begin
        if (sum_done) begin
          s_d.sum = sum_val; // [R8]
          s_d.result = sum_val;
          s_d.checksum_valid_flag = 1'b1;
          s_d.fsm = gcd_pkg::GCD_IDLE;
        end
      end
      gcd_pkg::GCD_SHORT: begin
        // Host holds sense current at zero for the whole phase [R14]
        if (tmr_done) begin
          s_d.short_en = 1'b0;
          if (s_q.board) begin
            s_d.first = cc_sample_in; // [R13]
            s_d.tmr_go = 1'b1;
            s_d.fsm = gcd_pkg::GCD_OPEN;
          end else begin
            s_d.cc_off = cc_sample_in; // [R16]
            s_d.result = cc_sample_in;
            s_d.cca = 1'b0;
            s_d.fsm = gcd_pkg::GCD_IDLE;
          end
        end
      end
      gcd_pkg::GCD_OPEN: begin
        if (tmr_done) begin
          s_d.result = s_q.first - cc_sample_in; // [R13]
          s_d.fwr.en = 1'b1;
          s_d.fwr.sel = gcd_pkg::GCD_WR_BOARD;
          s_d.fwr.data = s_q.first - cc_sample_in;
          s_d.bca = 1'b1;
          s_d.cca = 1'b0;
          s_d.fsm = gcd_pkg::GCD_IDLE;
        end
      end
    endcase
    // Result words stay until the next accepted code or the end of a checksum or offset sequence [R25]
    if (take) begin
      s_d.last = cmd_code_in; // [R11]
      case (cmd_code_in)
        gcd_pkg::SC_STATUS: s_d.result = stat_w; // [R3]
        gcd_pkg::SC_DEV_TYPE: s_d.result = DEV_TYPE; // [R7]
        gcd_pkg::SC_FW_REV: s_d.result = FW_REV; // [R7]
        gcd_pkg::SC_SI_REV: s_d.result = SI_REV; // [R7]
        gcd_pkg::SC_RESET_CNT: s_d.result = {part_rst_cnt_in, full_rst_cnt_in}; // [R10]
        gcd_pkg::SC_LAST_SC: s_d.result = s_q.last; // [R11]
        gcd_pkg::SC_CHEMISTRY_IDENTIFIER_REPORT: s_d.result = CHEMISTRY_IDENTIFIER_REPORT; // [R12]
        gcd_pkg::SC_FLASH_SUM: begin
          if (!s_q.locked && s_q.fsm == gcd_pkg::GCD_IDLE) begin
            s_d.sum_go = 1'b1; // [R8]
            s_d.fsm = gcd_pkg::GCD_SUM;
          end else begin
            s_d.result = s_q.sum; // [R9]
          end
        end
        gcd_pkg::SC_BOARD_OFF: begin
          if (s_q.locked) begin
            s_d.result = flash_board_off_in; // [R15]
          end else if (s_q.fsm == gcd_pkg::GCD_IDLE) begin
            s_d.board = 1'b1; // [R13]
            s_d.short_en = 1'b1;
            s_d.cca = 1'b1;
            s_d.tmr_go = 1'b1;
            s_d.fsm = gcd_pkg::GCD_SHORT;
          end
        end
        gcd_pkg::SC_CC_OFF: begin
          if (s_q.locked) begin
            s_d.result = flash_cc_off_in; // [R17]
          end else if (s_q.fsm == gcd_pkg::GCD_IDLE) begin
            s_d.board = 1'b0; // [R16]
            s_d.short_en = 1'b1;
            s_d.cca = 1'b1;
            s_d.tmr_go = 1'b1;
            s_d.fsm = gcd_pkg::GCD_SHORT;
          end
        end
        gcd_pkg::SC_STORE_CC: begin
          // Held off while busy so it cannot collide with a board write
          if (s_q.fsm == gcd_pkg::GCD_IDLE) begin
            s_d.fwr.en = 1'b1; // [R18]
            s_d.fwr.sel = gcd_pkg::GCD_WR_CC;
            s_d.fwr.data = s_q.cc_off;
          end
        end
        gcd_pkg::SC_HIB_SET: s_d.hib = 1'b1; // [R19]
        gcd_pkg::SC_HIB_CLR: s_d.hib = 1'b0; // [R20]
        gcd_pkg::SC_LOCK: s_d.locked = 1'b1; // [R21]
        gcd_pkg::SC_GAUGE_START: begin
          s_d.gauge_start = 1'b1; // [R22]
          s_d.upd = gcd_pkg::UPD_STATUS_RUN;
          s_d.voltage_ok_flag = 1'b1;
          s_d.capacity_update_enable_flag = 1'b1;
        end
        default: begin
        end
      endcase
    end
    // Busy kept in its own flop so the port comes straight from a register
    s_d.busy = (s_d.fsm != gcd_pkg::GCD_IDLE);
  end

  // State register; request flag clear at reset
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0; // [R6]
      s_q.result <= gcd_pkg::RESULT_RST;
      s_q.upd <= gcd_pkg::UPD_STATUS_RST;
    end else begin
      s_q <= s_d;
    end
  end

  gcd_phase_timer #(
    .CYC(PHASE_CYC)
  ) u_timer (
    .clk_in(sys_clk_in),
    .rst_n_in(rst_n),
    .start_in(s_q.tmr_go),
    .done_out(tmr_done)
  );

  gcd_flash_sum #(
    .DEPTH(SUM_DEPTH),
    .AW(SUM_AW)
  ) u_sum (
    .clk_in(sys_clk_in),
    .rst_n_in(rst_n),
    .start_in(s_q.sum_go),
    .data_in(flash_data_in),
    .rd_out(flash_rd_out),
    .addr_out(flash_addr_out),
    .done_out(sum_done),
    .sum_out(sum_val)
  );

  assign result_out = s_q.result;
  assign locked_out = s_q.locked;
  assign hib_req_out = s_q.hib;
  assign short_en_out = s_q.short_en;
  assign busy_out = s_q.busy;
  assign gauge_start_out = s_q.gauge_start;
  assign upd_status_out = s_q.upd;
  assign flash_wr_out = s_q.fwr;

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_n);

  property p_lock_gate;
    cmd_wr_in && s_q.locked && cmd_code_in == gcd_pkg::SC_GAUGE_START |=> !gauge_start_out && upd_status_out == $past(upd_status_out);
  endproperty
  a_lock_gate: assert property (p_lock_gate) else $error("locked gauging start acted"); // [R2]
  property p_status;
    take && cmd_code_in == gcd_pkg::SC_STATUS |=> result_out == $past(stat_w);
  endproperty
  a_status: assert property (p_status) else $error("status word not returned"); // [R3]
  property p_stat_bits;
    stat_w[13] == locked_out && stat_w[6] == hib_req_out && stat_w[15] == 1'b0 && stat_w[7] == 1'b0;
  endproperty
  a_stat_bits: assert property (p_stat_bits) else $error("status bit placement wrong"); // [R4]
  property p_hib_rst;
    $past(!rst_n) |-> !hib_req_out;
  endproperty
  a_hib_rst: assert property (p_hib_rst) else $error("request flag not clear after reset"); // [R6]
  property p_sum_locked;
    cmd_wr_in && s_q.locked && cmd_code_in == gcd_pkg::SC_FLASH_SUM |=> !flash_rd_out && result_out == $past(s_q.sum);
  endproperty
  a_sum_locked: assert property (p_sum_locked) else $error("locked checksum recomputed"); // [R9]
  property p_rst_cnt;
    take && cmd_code_in == gcd_pkg::SC_RESET_CNT |=> result_out == {$past(part_rst_cnt_in), $past(full_rst_cnt_in)};
  endproperty
  a_rst_cnt: assert property (p_rst_cnt) else $error("reset counts misplaced"); // [R10]
  property p_last;
    take && cmd_code_in == gcd_pkg::SC_LAST_SC |=> result_out == $past(s_q.last);
  endproperty
  a_last: assert property (p_last) else $error("previous code not returned"); // [R11]
  property p_board_done;
    s_q.fsm == gcd_pkg::GCD_OPEN && tmr_done && !cmd_wr_in
      |=> flash_wr_out.en && s_q.bca && result_out == flash_wr_out.data;
  endproperty
  a_board_done: assert property (p_board_done) else $error("board offset not stored"); // [R13]
  property p_meas_locked;
    cmd_wr_in && s_q.locked && (cmd_code_in == gcd_pkg::SC_BOARD_OFF || cmd_code_in == gcd_pkg::SC_CC_OFF)
      |=> !short_en_out ##1 !short_en_out;
  endproperty
  a_meas_locked: assert property (p_meas_locked) else $error("locked offset measured"); // [R15]
  property p_hib_clr;
    take && cmd_code_in == gcd_pkg::SC_HIB_CLR |=> !hib_req_out;
  endproperty
  a_hib_clr: assert property (p_hib_clr) else $error("request flag not cleared"); // [R20]
  property p_qen_hold;
    s_q.capacity_update_enable_flag |=> s_q.capacity_update_enable_flag;
  endproperty
  a_qen_hold: assert property (p_qen_hold) else $error("capacity enable fell"); // [R22]
  property p_undef;
    cmd_wr_in && !is_known(cmd_code_in) && !busy_out |=> $stable(result_out) && $stable(locked_out) && $stable(s_q.last);
  endproperty
  a_undef: assert property (p_undef) else $error("undefined code changed state"); // [R24]

  c_board: cover property (s_q.fsm == gcd_pkg::GCD_OPEN && tmr_done);
  c_sum: cover property (s_q.fsm == gcd_pkg::GCD_SUM && sum_done);
  c_lock_then_read: cover property (locked_out && take && cmd_code_in == gcd_pkg::SC_FLASH_SUM);
endmodule

// ---- bench/gcd_host_model.sv ----
`timescale 1ns/1ps
module gcd_host_model #(
  parameter int AW = 2
) (
  input wire logic clk_in,
  input wire logic flash_rd_in,
  input wire logic [AW-1:0] flash_addr_in,
  output logic cmd_wr_out,
  output logic [15:0] cmd_code_out,
  output logic [7:0] flash_data_out
);
  initial begin
    cmd_wr_out = 1'b0;
    cmd_code_out = 16'h0000;
    flash_data_out = 8'h00;
  end

  // Whole code word in one strobe; caller reads the result afterwards
  task automatic send(input logic [15:0] code);
    @(posedge clk_in);
    #1;
    cmd_wr_out = 1'b1;
    cmd_code_out = code;
    @(posedge clk_in);
    #1;
    cmd_wr_out = 1'b0;
    cmd_code_out = ~code; // Stale code must never look valid
  endtask

  // Flash byte one cycle after the read strobe; churns otherwise
  always @(posedge clk_in) begin
    if (flash_rd_in === 1'b1) begin
      flash_data_out <= 8'h50 + 8'(flash_addr_in);
    end else begin
      flash_data_out <= ~flash_data_out;
    end
  end
endmodule

// ---- bench/test_gauge_control_subcommand_decoder.sv ----
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin errors++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
module test_gauge_control_subcommand_decoder;
  localparam logic [15:0] DT = 16'h5a01; // Arbitrary value
  localparam logic [15:0] FW = 16'h0203; // Arbitrary value
  localparam logic [15:0] SI = 16'h0004; // Arbitrary value
  localparam logic [15:0] CH = 16'h0777; // Arbitrary value
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic cmd_wr;
  logic [15:0] cmd_code;
  gcd_pkg::gcd_live_t live = 4'b1011;
  logic volt_bad = 1'b0;
  logic hib_exit = 1'b0;
  logic [15:0] cc_sample = 16'h0000;
  logic [7:0] full_cnt = 8'h3c;
  logic [7:0] part_cnt = 8'h05;
  logic [15:0] bd_flash = 16'h0bd1;
  logic [15:0] cc_flash = 16'h0cc5;
  logic [7:0] fdata;
  logic [15:0] result;
  logic locked;
  logic hib;
  logic short_en;
  logic busy;
  logic gstart;
  logic [7:0] upd;
  logic frd;
  logic [1:0] faddr;
  gcd_pkg::gcd_fwr_t fwr;
  gcd_pkg::gcd_fwr_t wr_q;
  int wr_n = 0;
  int gs_n = 0;
  int errors = 0;
  int total_checks = 0;
  logic lk = 0, checksum_valid_flag = 0, cca = 0, bca = 0, hb = 0, voltage_ok_flag = 0, capacity_update_enable_flag = 0;
  logic [15:0] r;
  int n;

  always #5 sys_clk = ~sys_clk;

  gcd_subcmd_decoder #(.PHASE_CYC(20), .SUM_DEPTH(4), .DEV_TYPE(DT), .FW_REV(FW), .SI_REV(SI), .CHEMISTRY_IDENTIFIER_REPORT(CH)) dut (
    .sys_clk_in(sys_clk), .arst_n_in(arst_n), .cmd_wr_in(cmd_wr), .cmd_code_in(cmd_code), .live_in(live),
    .volt_bad_in(volt_bad), .hib_exit_in(hib_exit), .full_rst_cnt_in(full_cnt), .part_rst_cnt_in(part_cnt),
    .cc_sample_in(cc_sample), .flash_board_off_in(bd_flash), .flash_cc_off_in(cc_flash),
    .flash_data_in(fdata), .result_out(result), .locked_out(locked), .hib_req_out(hib),
    .short_en_out(short_en), .busy_out(busy), .gauge_start_out(gstart), .upd_status_out(upd),
    .flash_rd_out(frd), .flash_addr_out(faddr), .flash_wr_out(fwr));

  gcd_host_model #(.AW(2)) host (.clk_in(sys_clk), .flash_rd_in(frd), .flash_addr_in(faddr),
    .cmd_wr_out(cmd_wr), .cmd_code_out(cmd_code), .flash_data_out(fdata));

  // One-cycle pulses are caught here so tasks can look later
  always @(posedge sys_clk) begin
    if (fwr.en === 1'b1) begin
      wr_q <= fwr;
      wr_n <= wr_n + 1;
    end
    if (gstart === 1'b1) begin
      gs_n <= gs_n + 1;
    end
  end

  function automatic logic [15:0] stat();
    logic [15:0] s;
    s = 16'h0000;
    s[gcd_pkg::SB_FAS] = live.full_access_locked_flag;
    s[gcd_pkg::SB_LOCKED] = lk;
    s[gcd_pkg::SB_CSV] = checksum_valid_flag;
    s[gcd_pkg::SB_CCA] = cca;
    s[gcd_pkg::SB_BCA] = bca;
    s[gcd_pkg::SB_HIB] = hb;
    s[gcd_pkg::SB_SLEEP] = live.sleep;
    s[gcd_pkg::SB_CONSTANT_POWER_FLAG] = live.constant_power_flag;
    s[gcd_pkg::SB_RESISTANCE_UPDATE_DISABLE_FLAG] = live.resistance_update_disable_flag;
    s[gcd_pkg::SB_VOK] = voltage_ok_flag;
    s[gcd_pkg::SB_QEN] = capacity_update_enable_flag;
    return s;
  endfunction

  function automatic logic [15:0] fsum();
    logic [15:0] s;
    s = 16'h0000;
    for (int a = 0; a < 4; a++) s = s + 16'h0050 + 16'(a);
    return s;
  endfunction

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask

  // Extra edge so a result answered up to one cycle late is settled; checksum and offsets need wait_idle
  task automatic issue(input logic [15:0] c);
    host.send(c);
    tick();
  endtask

  task automatic wait_idle();
    for (int i = 0; i < 300 && busy !== 1'b0; i++) tick();
    if (busy !== 1'b0) begin
      errors++;
      $display("MISMATCH busy exp 0 got %b", busy);
      conclude();
    end
    tick();
  endtask

  task automatic t_reset();
    `CHK("hib", 1'b0, hib)
    `CHK("upd", 8'h00, upd)
    issue(16'h0000);
    `CHK("status", stat(), result)
    $display("done reset");
  endtask

  task automatic t_ids();
    issue(16'h0001);
    `CHK("type", DT, result)
    issue(16'h0002);
    `CHK("fw", FW, result)
    issue(16'h0003);
    `CHK("si", SI, result)
    issue(16'h0008);
    `CHK("chem", CH, result)
    issue(16'h0005);
    `CHK("rstcnt", 16'h053c, result)
    full_cnt = 8'h81;
    part_cnt = 8'h7e;
    issue(16'h0005);
    `CHK("rstcnt2", 16'h7e81, result)
    issue(16'h0002);
    issue(16'h0006);
    `CHK("undef", FW, result)
    issue(16'h0007);
    `CHK("last", 16'h0002, result)
    $display("done ids");
  endtask

  task automatic t_hib();
    issue(16'h0011);
    hb = 1;
    `CHK("hibset", 1'b1, hib)
    live = 4'b0100; // Sleep only, other live bits flip
    issue(16'h0000);
    `CHK("status", stat(), result)
    hib_exit = 1'b1;
    tick();
    hib_exit = 1'b0;
    tick();
    hb = 0;
    `CHK("hibexit", 1'b0, hib)
    issue(16'h0011);
    issue(16'h0012);
    `CHK("hibclr", 1'b0, hib)
    $display("done hib");
  endtask

  task automatic t_meas();
    issue(16'h0004);
    wait_idle();
    checksum_valid_flag = 1;
    `CHK("sum", fsum(), result)
    cc_sample = 16'h0123;
    issue(16'h000a);
    `CHK("short", 1'b1, short_en)
    cca = 1;
    issue(16'h0000);
    `CHK("status", stat(), result)
    wait_idle();
    cca = 0;
    `CHK("ccoff", 16'h0123, result)
    n = wr_n;
    issue(16'h000b);
    tick();
    `CHK("ccwr", n + 1, wr_n)
    `CHK("ccsel", gcd_pkg::GCD_WR_CC, wr_q.sel)
    `CHK("ccdata", 16'h0123, wr_q.data)
    // Sense current held still per phase, as the host must
    cc_sample = 16'h0400;
    issue(16'h0009);
    `CHK("short", 1'b1, short_en)
    for (int i = 0; i < 100 && short_en === 1'b1; i++) tick();
    `CHK("shortend", 1'b0, short_en)
    cc_sample = 16'h0150;
    wait_idle();
    bca = 1;
    `CHK("board", 16'h02b0, result)
    `CHK("bdsel", gcd_pkg::GCD_WR_BOARD, wr_q.sel)
    `CHK("bddata", 16'h02b0, wr_q.data)
    issue(16'h0000);
    `CHK("status", stat(), result)
    $display("done meas");
  endtask

  task automatic t_gauge();
    n = gs_n;
    issue(16'h0021);
    tick();
    voltage_ok_flag = 1;
    capacity_update_enable_flag = 1;
    `CHK("gstart", n + 1, gs_n)
    `CHK("upd", 8'h01, upd)
    issue(16'h0000);
    `CHK("status", stat(), result)
    volt_bad = 1'b1;
    tick();
    voltage_ok_flag = 0;
    issue(16'h0000);
    `CHK("vokclr", stat(), result)
    $display("done gauge");
  endtask

  task automatic t_lock();
    issue(16'h0020);
    lk = 1;
    `CHK("locked", 1'b1, locked)
    issue(16'h0000);
    `CHK("status", stat(), result)
    r = result;
    issue(16'h0005);
    `CHK("refuse5", r, result)
    issue(16'h0007);
    `CHK("refuse7", r, result)
    issue(16'h0004);
    `CHK("sumkept", fsum(), result)
    `CHK("nobusy", 1'b0, busy)
    issue(16'h0009);
    `CHK("bdstored", 16'h0bd1, result)
    issue(16'h000a);
    `CHK("ccstored", 16'h0cc5, result)
    `CHK("noshort", 1'b0, short_en)
    n = gs_n;
    issue(16'h0021);
    tick();
    `CHK("nostart", n, gs_n)
    issue(16'h0011);
    `CHK("lkhib", 1'b1, hib)
    issue(16'h0001);
    `CHK("lktype", DT, result)
    $display("done lock");
  endtask

  initial begin
    repeat (2) @(posedge sys_clk);
    #1;
    arst_n = 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    t_reset();
    t_ids();
    t_hib();
    t_meas();
    t_gauge();
    t_lock();
    conclude();
  end
endmodule
